// ---- twsc_pkg.sv ----
// Package for the two-wire slave control and status block.
// Assumes an APB master on mclk and an open-drain two-wire bus outside.
package twsc_pkg;

	// Register byte addresses on APB
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0C;

	// Operating mode codes
	localparam logic [2:0] MODE_TWS = 3'h6;
	localparam logic [2:0] MODE_SPI_SLV = 3'h5;
	localparam logic [2:0] MODE_SPI_MST_TOP = 3'h4;
	localparam logic [2:0] MODE_UNUSED = 3'h7;

	// Debounce selection and sample counts
	localparam logic [1:0] DEB_NONE = 2'h0;
	localparam logic [1:0] DEB_TWO = 2'h1;
	localparam logic [2:0] DEB_CNT_NONE = 3'h0;
	localparam logic [2:0] DEB_CNT_TWO = 3'h2;
	localparam logic [2:0] DEB_CNT_FOUR = 3'h4;

	// Index of the last bit of a byte
	localparam logic [3:0] BIT_LAST = 4'h7;

	typedef struct packed {
		logic [2:0] op_mode;
		logic uart_sel;
		logic [1:0] deb_sel;
		logic enable;
		logic spare;
	} twsc_mode_t;

	typedef struct packed {
		logic byte_done;
		logic addr_match;
		logic bus_busy;
		logic tx_sel;
		logic ack_to_send;
		logic master_dir;
		logic wake_en;
		logic rx_ack;
	} twsc_flags_t;

	localparam twsc_mode_t MODE_RST = twsc_mode_t'(8'hE0);
	localparam twsc_flags_t FLAGS_RST = twsc_flags_t'(8'h81);
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;

	typedef enum logic [3:0] {
		TWSC_IDLE, TWSC_ADDR, TWSC_RX, TWSC_TX, TWSC_ACK, TWSC_TACK,
		TWSC_HOLD, TWSC_SKIP
	} twsc_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} twsc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} twsc_apb_rsp_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} twsc_pin_in_t;

	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} twsc_pin_out_t;

	typedef struct packed {
		logic tws;
		logic spi_slv;
		logic spi_mst;
		logic uart;
	} twsc_sel_t;

	typedef struct packed {
		logic byte_done_evt;
		logic match_evt;
		logic wake_req;
	} twsc_evt_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] f;
		logic [1:0][2:0] cnt;
	} twsc_deb_st_t;

	localparam twsc_deb_st_t DEB_ST_RST = '{s1: 2'h3, s2: 2'h3, f: 2'h3,
		cnt: '0};

	typedef struct packed {
		twsc_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] sh;
		logic ackv;
		logic ack_on;
		twsc_mode_t mode;
		twsc_flags_t flags;
		logic [7:0] data;
		logic [7:0] own;
		logic scl_p;
		logic sda_p;
		logic scl_oe;
		logic sda_oe;
		logic [31:0] prdata;
		logic done_evt;
		logic match_evt;
		logic wake_req;
	} twsc_st_t;

	localparam twsc_st_t ST_RST = '{st: TWSC_IDLE, bitcnt: 4'h0, sh: 8'h00,
		ackv: 1'b0, ack_on: 1'b0, mode: MODE_RST, flags: FLAGS_RST,
		data: DATA_RST, own: OWN_ADDR_RST, scl_p: 1'b1, sda_p: 1'b1,
		scl_oe: 1'b0, sda_oe: 1'b0, prdata: 32'h0000_0000,
		done_evt: 1'b0, match_evt: 1'b0, wake_req: 1'b0};

	function automatic logic tws_on(input twsc_mode_t m);
		return m.enable & ~m.uart_sel & (m.op_mode == MODE_TWS);
	endfunction

	function automatic logic reg_mapped(input logic [7:0] a);
		return (a == OFS_MODE) | (a == OFS_FLAGS) | (a == OFS_DATA) |
			(a == OFS_ADDR);
	endfunction

endpackage

// ---- twsc_deb.sv ----
// Synchroniser and debounce filter for the two bus lines.
// Assumes raw pin levels from outside the mclk domain.
`timescale 1ns/100ps
module twsc_deb(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Filter selection
	input wire logic [1:0] deb_sel,
	// Raw pins
	input wire twsc_pkg::twsc_pin_in_t pin,
	// Filtered levels
	output twsc_pkg::twsc_pin_in_t filt
);
	import twsc_pkg::*;

	twsc_deb_st_t s_r;
	twsc_deb_st_t s_nxt;
	logic [2:0] lim;

	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = pin;
		s_nxt.s2 = s_r.s1;
		case (deb_sel)
			DEB_NONE: lim = DEB_CNT_NONE;
			DEB_TWO: lim = DEB_CNT_TWO;
			default: lim = DEB_CNT_FOUR;
		endcase
		// Both lines get the same delay so START and STOP stay aligned
		for (int i = 0; i < 2; i++) begin
			if (s_r.s2[i] == s_r.f[i]) begin
				s_nxt.cnt[i] = 3'h0;
			end else if (lim == DEB_CNT_NONE ||
				s_r.cnt[i] + 3'h1 >= lim) begin
				s_nxt.f[i] = s_r.s2[i];
				s_nxt.cnt[i] = 3'h0;
			end else begin
				s_nxt.cnt[i] = s_r.cnt[i] + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_r <= DEB_ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign filt = s_r.f;
endmodule

// ---- twsc_top.sv ----
// Two-wire slave control and status logic with its APB register file.
// Assumes an APB master on mclk and open-drain bus lines pulled high.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
module twsc_top(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// APB slave
	input wire twsc_pkg::twsc_apb_req_t apb_req,
	output twsc_pkg::twsc_apb_rsp_t apb_rsp,
	// Bus pins
	input wire twsc_pkg::twsc_pin_in_t pin_in,
	output twsc_pkg::twsc_pin_out_t pin_out,
	// Mode decode and events
	output twsc_pkg::twsc_sel_t unit_sel,
	output twsc_pkg::twsc_evt_t evt
);
	import twsc_pkg::*;

	twsc_st_t s_r;
	twsc_st_t s_nxt;
	twsc_pin_in_t filt;
	logic [1:0] deb_use;
	logic active;
	logic setup;
	logic acc;
	logic wr;
	logic data_rd;
	logic data_wr;
	logic rise;
	logic fall;
	logic start;
	logic stop;

	// Filtering only applies in two-wire mode
	assign active = tws_on(s_r.mode);
	assign deb_use = active ? s_r.mode.deb_sel : DEB_NONE;

	twsc_deb u_deb (
		.mclk(mclk),
		.nrst(nrst),
		.deb_sel(deb_use),
		.pin(pin_in),
		.filt(filt)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.done_evt = 1'b0;
		s_nxt.match_evt = 1'b0;
		s_nxt.wake_req = 1'b0;

		setup = apb_req.psel & ~apb_req.penable;
		acc = apb_req.psel & apb_req.penable;
		wr = acc & apb_req.pwrite;
		data_rd = acc & ~apb_req.pwrite & (apb_req.paddr == OFS_DATA);
		data_wr = wr & (apb_req.paddr == OFS_DATA);

		// Read data is captured in setup so prdata comes from a flop
		if (setup) begin
			case (apb_req.paddr)
				OFS_MODE: s_nxt.prdata = {24'h000000, s_r.mode};
				OFS_FLAGS: s_nxt.prdata = {24'h000000, s_r.flags};
				OFS_DATA: s_nxt.prdata = {24'h000000, s_r.data};
				OFS_ADDR: s_nxt.prdata = {24'h000000, s_r.own};
				default: s_nxt.prdata = 32'h0000_0000;
			endcase
		end

		if (wr) begin
			case (apb_req.paddr)
				OFS_MODE: begin
					s_nxt.mode = twsc_mode_t'(apb_req.pwdata[7:0]);
					if (!s_r.mode.enable && tws_on(s_nxt.mode)) begin
						// Status flags restart; software bits stay
						s_nxt.flags.byte_done = FLAGS_RST.byte_done;
						s_nxt.flags.addr_match = FLAGS_RST.addr_match;
						s_nxt.flags.bus_busy = FLAGS_RST.bus_busy;
						s_nxt.flags.master_dir = FLAGS_RST.master_dir;
						s_nxt.flags.rx_ack = FLAGS_RST.rx_ack;
					end
				end
				OFS_FLAGS: begin
					s_nxt.flags.tx_sel = apb_req.pwdata[4];
					s_nxt.flags.ack_to_send = apb_req.pwdata[3];
					s_nxt.flags.wake_en = apb_req.pwdata[1];
				end
				OFS_DATA: begin
					s_nxt.data = apb_req.pwdata[7:0];
				end
				OFS_ADDR: begin
					s_nxt.own = apb_req.pwdata[7:0];
				end
				default: begin
				end
			endcase
		end

		s_nxt.scl_p = filt.scl;
		s_nxt.sda_p = filt.sda;
		rise = filt.scl & ~s_r.scl_p;
		fall = ~filt.scl & s_r.scl_p;
		start = s_r.scl_p & filt.scl & s_r.sda_p & ~filt.sda;
		stop = s_r.scl_p & filt.scl & ~s_r.sda_p & filt.sda;

		if (!active) begin
			// Pins fully released and sequencer parked
			s_nxt.st = TWSC_IDLE;
			s_nxt.scl_oe = 1'b0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.ack_on = 1'b0;
		end else if (start) begin
			s_nxt.flags.bus_busy = 1'b1;
			s_nxt.flags.byte_done = 1'b0;
			s_nxt.flags.addr_match = 1'b0;
			s_nxt.bitcnt = 4'h0;
			s_nxt.ack_on = 1'b0;
			s_nxt.scl_oe = 1'b0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.st = TWSC_ADDR;
		end else if (stop) begin
			s_nxt.flags.bus_busy = 1'b0;
			s_nxt.scl_oe = 1'b0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.ack_on = 1'b0;
			s_nxt.st = TWSC_IDLE;
		end else begin
			case (s_r.st)
				TWSC_ADDR: begin
					if (rise) begin
						s_nxt.sh = {s_r.sh[6:0], filt.sda};
						s_nxt.bitcnt = s_r.bitcnt + 4'h1;
						if (s_r.bitcnt == BIT_LAST) begin
							if (s_r.sh[6:0] == s_r.own[7:1]) begin
								s_nxt.flags.addr_match = 1'b1;
								s_nxt.flags.master_dir = filt.sda;
								s_nxt.match_evt = 1'b1;
								s_nxt.wake_req = s_r.flags.wake_en;
								s_nxt.ackv = 1'b0;
								s_nxt.st = TWSC_ACK;
							end else begin
								// Not ours: stay off the bus until next START
								s_nxt.st = TWSC_SKIP;
							end
						end
					end
				end
				TWSC_RX: begin
					if (rise) begin
						s_nxt.sh = {s_r.sh[6:0], filt.sda};
						s_nxt.bitcnt = s_r.bitcnt + 4'h1;
						if (s_r.bitcnt == BIT_LAST) begin
							s_nxt.data = {s_r.sh[6:0], filt.sda};
							// Software must have cleared this beforehand
							s_nxt.ackv = s_r.flags.ack_to_send;
							s_nxt.st = TWSC_ACK;
						end
					end
				end
				TWSC_ACK: begin
					if (fall) begin
						if (!s_r.ack_on) begin
							s_nxt.sda_oe = ~s_r.ackv;
							s_nxt.ack_on = 1'b1;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.ack_on = 1'b0;
							s_nxt.flags.byte_done = 1'b1;
							s_nxt.done_evt = 1'b1;
							s_nxt.scl_oe = 1'b1;
							s_nxt.st = TWSC_HOLD;
						end
					end
				end
				TWSC_HOLD: begin
					// Stretching covers the gap until software services data
					s_nxt.scl_oe = 1'b1;
					if (s_r.flags.tx_sel && data_wr) begin
						s_nxt.scl_oe = 1'b0;
						s_nxt.sh = apb_req.pwdata[7:0];
						s_nxt.sda_oe = ~apb_req.pwdata[7];
						s_nxt.bitcnt = 4'h0;
						s_nxt.flags.byte_done = 1'b0;
						s_nxt.flags.addr_match = 1'b0;
						s_nxt.st = TWSC_TX;
					end else if (!s_r.flags.tx_sel && data_rd) begin
						s_nxt.scl_oe = 1'b0;
						s_nxt.bitcnt = 4'h0;
						s_nxt.flags.byte_done = 1'b0;
						s_nxt.flags.addr_match = 1'b0;
						s_nxt.st = TWSC_RX;
					end
				end
				TWSC_TX: begin
					if (fall) begin
						if (s_r.bitcnt == BIT_LAST) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st = TWSC_TACK;
						end else begin
							s_nxt.bitcnt = s_r.bitcnt + 4'h1;
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
						end
					end
				end
				TWSC_TACK: begin
					if (rise) begin
						s_nxt.flags.rx_ack = filt.sda;
					end
					if (fall) begin
						s_nxt.flags.byte_done = 1'b1;
						s_nxt.done_evt = 1'b1;
						if (s_r.flags.rx_ack) begin
							// Master declined: leave data free for STOP
							s_nxt.st = TWSC_SKIP;
						end else begin
							s_nxt.scl_oe = 1'b1;
							s_nxt.st = TWSC_HOLD;
						end
					end
				end
				TWSC_IDLE, TWSC_SKIP: begin
					s_nxt.scl_oe = 1'b0;
					s_nxt.sda_oe = 1'b0;
				end
				default: begin
					s_nxt.st = TWSC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_r <= ST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Zero wait states; unmapped access reports an error
	assign apb_rsp.prdata = s_r.prdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = acc & ~reg_mapped(apb_req.paddr);

	// Open drain: pins only ever pull low
	assign pin_out.scl_o = 1'b0;
	assign pin_out.scl_oe = s_r.scl_oe;
	assign pin_out.sda_o = 1'b0;
	assign pin_out.sda_oe = s_r.sda_oe;

	// Mode decode, meaningful only with UART bit clear
	assign unit_sel.uart = s_r.mode.uart_sel;
	assign unit_sel.tws = ~s_r.mode.uart_sel &
		(s_r.mode.op_mode == MODE_TWS);
	assign unit_sel.spi_slv = ~s_r.mode.uart_sel &
		(s_r.mode.op_mode == MODE_SPI_SLV);
	assign unit_sel.spi_mst = ~s_r.mode.uart_sel &
		(s_r.mode.op_mode <= MODE_SPI_MST_TOP);

	assign evt.byte_done_evt = s_r.done_evt;
	assign evt.match_evt = s_r.match_evt;
	assign evt.wake_req = s_r.wake_req;
endmodule

// ---- twsc_monitor.sv ----
// Port checker for the two-wire slave block.
// Bound to twsc_top; sees only its ports.
`timescale 1ns/100ps
module twsc_monitor(
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Watched ports
	input wire twsc_pkg::twsc_apb_req_t apb_req,
	input wire twsc_pkg::twsc_apb_rsp_t apb_rsp,
	input wire twsc_pkg::twsc_pin_in_t pin_in,
	input wire twsc_pkg::twsc_pin_out_t pin_out,
	input wire twsc_pkg::twsc_sel_t unit_sel,
	input wire twsc_pkg::twsc_evt_t evt
);
	import twsc_pkg::*;
	logic acc, wm, rel;
	assign acc = apb_req.psel & apb_req.penable;
	assign wm = acc & apb_req.pwrite & apb_req.paddr == OFS_MODE;
	assign rel = wm | acc & apb_req.paddr == OFS_DATA;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	property p_mode;
		wm |=> unit_sel.tws == ($past(apb_req.pwdata[7:5]) == MODE_TWS &
			!$past(apb_req.pwdata[4]));
	endproperty
	a_mode: assert property (p_mode) else $error("bad decode");
	property p_uart;
		unit_sel.uart |-> !(unit_sel.tws | unit_sel.spi_slv | unit_sel.spi_mst);
	endproperty
	a_uart: assert property (p_uart) else $error("bad uart");
	property p_off;
		wm & !apb_req.pwdata[1] |-> ##2 !(pin_out.scl_oe | pin_out.sda_oe);
	endproperty
	a_off: assert property (p_off) else $error("pins held");
	property p_quiet;
		!unit_sel.tws & !$past(unit_sel.tws) |->
			!(evt.match_evt | evt.byte_done_evt);
	endproperty
	a_quiet: assert property (p_quiet) else $error("event off");
	property p_ack;
		evt.match_evt |-> ##[1:60] pin_out.sda_oe;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_wake;
		evt.wake_req |-> evt.match_evt;
	endproperty
	a_wake: assert property (p_wake) else $error("bad wake");
	property p_str;
		$rose(pin_out.scl_oe) |-> evt.byte_done_evt;
	endproperty
	a_str: assert property (p_str) else $error("bad stretch");
	property p_hold;
		$fell(pin_out.scl_oe) |-> $past(rel) | $past(rel, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("early release");
	c_wake: cover property (evt.wake_req);
	c_done: cover property (evt.byte_done_evt);
	c_err: cover property (apb_rsp.pslverr);
endmodule
bind twsc_top twsc_monitor u_mon(.mclk(mclk), .nrst(nrst), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .pin_in(pin_in), .pin_out(pin_out),
	.unit_sel(unit_sel), .evt(evt));

// ---- twsc_bus_master.sv ----
// Two-wire bus master model.
// Assumes the bench resolves both lines with pull-ups.
`timescale 1ns/100ps
module twsc_bus_master(
	// Resolved lines
	input wire logic scl,
	input wire logic sda,
	// Pull-low requests
	output logic scl_dn,
	output logic sda_dn
);
	initial begin
		scl_dn = 1'b0;
		sda_dn = 1'b0;
	end
	// Bounded wait, slave may stretch
	task automatic up();
		int w;
		w = 0;
		scl_dn = 1'b0;
		while (!scl && w++ < 9000) #40;
		#120;
	endtask
	// Long low phase so the slave's filtered stretch lands first
	task automatic clk_bit(input logic b, output logic r);
		#120;
		sda_dn = !b;
		#320;
		up();
		r = sda;
		#120;
		scl_dn = 1'b1;
	endtask
	task automatic bus_start();
		sda_dn = 1'b0;
		#120;
		up();
		sda_dn = 1'b1;
		#240;
		scl_dn = 1'b1;
	endtask
	task automatic bus_stop();
		#120;
		sda_dn = 1'b1;
		#320;
		up();
		sda_dn = 1'b0;
		#240;
	endtask
	task automatic xfer(input logic [7:0] d, input logic k,
		output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(k, r);
	endtask
endmodule

// ---- twsc_top_test.sv ----
// Self-checking bench for the two-wire slave block.
// Uses the bus master model; the checker is bound on its own.
`timescale 1ns/100ps
module twsc_top_test;
	import twsc_pkg::*;
	logic mclk, nrst, scl_dn, sda_dn, a, er;
	twsc_apb_req_t apb_req;
	twsc_apb_rsp_t apb_rsp;
	twsc_pin_in_t pin_in;
	twsc_pin_out_t pin_out;
	twsc_sel_t unit_sel;
	twsc_evt_t evt;
	int error_cnt, cmp_count, wakes, dones, seed;
	logic [7:0] rd, own, q, f, d1, d2;
	logic [7:0] tq[$], rq[$], fq[$], lq[$];
	assign pin_in.scl = !(scl_dn | pin_out.scl_oe);
	assign pin_in.sda = !(sda_dn | pin_out.sda_oe);
	twsc_top u_dut(.mclk(mclk), .nrst(nrst), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .pin_in(pin_in), .pin_out(pin_out),
		.unit_sel(unit_sel), .evt(evt));
	twsc_bus_master u_mst(.scl(pin_in.scl), .sda(pin_in.sda),
		.scl_dn(scl_dn), .sda_dn(sda_dn));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = !mclk;
	end
	function automatic logic [3:0] sel_exp(logic [2:0] op, logic u);
		if (u) return 4'h1;
		return {op == 3'h6, op == 3'h5, op < 3'h5, 1'b0};
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	// No wait limit here; the watchdog ends a hung transfer
	task automatic apb(logic w, logic [7:0] ad, logic [7:0] d);
		@(posedge mclk);
		apb_req <= '{1'b1, 1'b0, w, ad, {24'h0, d}};
		@(posedge mclk);
		apb_req.penable <= 1'b1;
		@(posedge mclk);
		while (apb_rsp.pready !== 1'b1) @(posedge mclk);
		rd = apb_rsp.prdata[7:0];
		er = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask
	task automatic complete_run();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Software side: serves every stretch
	initial forever begin
		@(negedge mclk);
		if (pin_out.scl_oe === 1'b1) begin
			apb(1'b0, OFS_FLAGS, 8'h00);
			lq.push_back(rd);
			f = fq.pop_front();
			apb(1'b1, OFS_FLAGS, f);
			if (f[4]) apb(1'b1, OFS_DATA, tq.pop_front());
			else begin
				apb(1'b0, OFS_DATA, 8'h00);
				rq.push_back(rd);
			end
			repeat (3) @(posedge mclk);
		end
	end
	always @(posedge mclk) if (evt.wake_req === 1'b1) wakes++;
	always @(posedge mclk) if (evt.byte_done_evt === 1'b1) dones++;
	initial begin
		#3000000;
		error_cnt++;
		complete_run();
	end
	initial begin
		seed = 32'hA11B5CC2;
		error_cnt = 0;
		cmp_count = 0;
		wakes = 0;
		dones = 0;
		nrst = 1'b0;
		apb_req = '0;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		apb(1'b0, OFS_MODE, 8'h00);
		chk("mode", 8'hE0, rd);
		apb(1'b0, OFS_FLAGS, 8'h00);
		chk("flags", 8'h81, rd);
		chk("drive", 8'h00, {6'h0, pin_out.scl_o, pin_out.sda_o});
		apb(1'b0, 8'h10, 8'h00);
		chk("slverr", 8'h01, {7'h0, er});
		for (int m = 0; m < 16; m++) begin
			apb(1'b1, OFS_MODE, 8'(m << 4));
			@(negedge mclk);
			chk("sel", {4'h0, sel_exp(m[3:1], m[0])}, {4'h0, unit_sel});
		end
		own = 8'($random(seed));
		own[0] = 1'b0;
		apb(1'b1, OFS_ADDR, own);
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, OFS_MODE, {MODE_TWS, 1'b0, 2'(d), 2'h2});
			apb(1'b1, OFS_FLAGS, 8'h02);
			d1 = 8'($random(seed));
			d2 = 8'($random(seed));
			fq = '{8'h00, 8'h00, 8'h08, 8'h00};
			rq.delete();
			lq.delete();
			u_mst.bus_start();
			u_mst.xfer(own, 1'b1, q, a);
			chk("addr ack", 8'h00, {7'h0, a});
			u_mst.xfer(d1, 1'b1, q, a);
			u_mst.xfer(d2, 1'b1, q, a);
			chk("ack", 8'h00, {7'h0, a});
			u_mst.xfer(~d1, 1'b1, q, a);
			chk("nack", 8'h01, {7'h0, a});
			u_mst.bus_stop();
			chk("rx", d2, rq[2]);
			chk("match", 8'hE2, lq[0] & 8'hFE);
			chk("byte", 8'hA0, lq[1] & 8'hFE);
		end
		chk("wakes", 8'h04, 8'(wakes));
		u_mst.bus_start();
		u_mst.xfer(own ^ 8'h80, 1'b1, q, a);
		chk("other", 8'h01, {7'h0, a});
		u_mst.bus_stop();
		fq = '{8'h10, 8'h10};
		tq = '{d1, d2};
		u_mst.bus_start();
		u_mst.xfer(own | 8'h01, 1'b1, q, a);
		u_mst.xfer(8'hFF, 1'b0, q, a);
		chk("tx", d1, q);
		u_mst.xfer(8'hFF, 1'b1, q, a);
		chk("tx last", d2, q);
		repeat (10) @(negedge mclk);
		chk("sda free", 8'h00, {7'h0, pin_out.sda_oe});
		u_mst.bus_stop();
		apb(1'b0, OFS_FLAGS, 8'h00);
		chk("read flags", 8'h95, rd);
		apb(1'b1, OFS_MODE, {MODE_TWS, 5'h00});
		u_mst.bus_start();
		u_mst.xfer(own, 1'b1, q, a);
		chk("off ack", 8'h01, {7'h0, a});
		u_mst.bus_stop();
		apb(1'b0, OFS_FLAGS, 8'h00);
		chk("off flags", 8'h95, rd);
		apb(1'b1, OFS_MODE, {MODE_TWS, 5'h02});
		apb(1'b0, OFS_FLAGS, 8'h00);
		chk("on flags", 8'h91, rd);
		chk("dones", 8'h13, 8'(dones));
		complete_run();
	end
endmodule
